// ### verilog/sxb_consts.svh
// Constants for the serial transceiver buffer and flag block.
// Assumes a single 100 MHz clock; included by the package and the design files.
`ifndef SXB_CONSTS_SVH
`define SXB_CONSTS_SVH
`define SXB_FIFO_DEPTH 16
`define SXB_DATA_W 9
`define SXB_CNT_W 4
`define SXB_SIZE_5 3'h0
`define SXB_SIZE_6 3'h1
`define SXB_SIZE_7 3'h2
`define SXB_SIZE_8 3'h3
`define SXB_SIZE_9 3'h7
`define SXB_BASE_BITS 4'h5
`define SXB_DIV_W 16
`define SXB_DIV_DEFAULT 16'h0363
`endif

// ### verilog/sxb_pkg.sv
// Types shared by the serial transceiver buffer block.
// Assumes the constants header is on the include path.
`include "sxb_consts.svh"
package sxb_pkg;
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
    logic frame_err;
    logic overrun;
    logic parity_err;
  } sxb_rx_entry_t;
  typedef struct packed {
    logic [2:0] char_size;
    logic parity_enable;
    logic parity_odd;
    logic two_stop;
    logic sync_mode;
  } sxb_format_t;
endpackage

// ### verilog/sxb_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush input.
// Assumes one clock, synchronous active-high reset and a clock enable.
`timescale 1ns/100ps
`include "sxb_consts.svh"
module sxb_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = `SXB_FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_flush,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  always_comb begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (i_flush) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end else begin
      if (push) wr_d = AW'(wr_q + 1'b1);
      if (pop) rd_d = AW'(rd_q + 1'b1);
      cnt_d = (AW+1)'(cnt_q + push - pop);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (i_ce) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_ce && push && !i_flush) begin
      mem[wr_q] <= i_in_data;
    end
  end

  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem[rd_q];

  a_fifo_count: assert property (@(posedge i_clock) disable iff (i_reset)
    cnt_q <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule

// ### verilog/sxb_top.sv
// Transmit buffer, flags, parity, delayed disable, receiver and receive FIFO.
// Assumes one system clock; the transfer clock pin is sampled as a plain input.
`timescale 1ns/100ps
`include "sxb_consts.svh"
module sxb_top #(
  parameter logic [`SXB_DIV_W-1:0] BAUD_DIV = `SXB_DIV_DEFAULT
) (
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_CE,
  input wire sxb_pkg::sxb_format_t I_FORMAT,
  input wire logic I_TRANSMITTER_ENABLE,
  input wire logic I_RECEIVER_ENABLE,
  input wire logic I_TX_EMPTY_IRQ_ENABLE,
  input wire logic I_TX_COMPLETE_IRQ_ENABLE,
  input wire logic I_TX_NINTH_BIT,
  input wire logic I_DATA_WRITE,
  input wire logic [7:0] I_DATA_WDATA,
  input wire logic I_DATA_READ,
  input wire logic I_TX_COMPLETE_CLEAR,
  input wire logic I_TX_COMPLETE_IRQ_ACK,
  input wire logic I_RX_PIN,
  input wire logic I_TRANSFER_CLOCK_PIN,
  output logic O_TX_PIN,
  output logic O_TX_PIN_OVERRIDE,
  output logic O_RX_PIN_OVERRIDE,
  output logic O_TX_BUFFER_EMPTY_FLAG,
  output logic O_TX_COMPLETE_FLAG,
  output logic O_RX_COMPLETE_FLAG,
  output logic O_TX_EMPTY_IRQ,
  output logic O_TX_COMPLETE_IRQ,
  output sxb_pkg::sxb_rx_entry_t O_RX_HEAD
);
  typedef enum logic [1:0] {SXB_IDLE, SXB_START, SXB_BITS, SXB_STOP} sxb_state_t;

  // Bit tick: baud divider in asynchronous mode, rising transfer clock in synchronous mode.
  logic [`SXB_DIV_W-1:0] div_q, div_d;
  logic xck_q, xck_d, tick;
  always_comb begin
    xck_d = I_TRANSFER_CLOCK_PIN;
    div_d = (div_q == '0) ? BAUD_DIV : div_q - 1'b1;
    tick = I_FORMAT.sync_mode ? (I_TRANSFER_CLOCK_PIN && !xck_q) : (div_q == '0);
  end
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      div_q <= '0;
      xck_q <= 1'b0;
    end else if (I_CE) begin
      div_q <= div_d;
      xck_q <= xck_d;
    end
  end

  // Number of data bits and the data mask for the current character size.
  logic [`SXB_CNT_W-1:0] nbits;
  logic [8:0] dmask;
  always_comb begin
    nbits = (I_FORMAT.char_size == `SXB_SIZE_9) ? `SXB_CNT_W'(9) :
            `SXB_CNT_W'(`SXB_BASE_BITS + {1'b0, I_FORMAT.char_size[1:0]});
    dmask = 9'((10'h001 << nbits) - 10'h001);
  end

  // Transmitter.
  sxb_state_t tx_st_q, tx_st_d;
  logic [8:0] tbuf_q, tbuf_d, tsh_q, tsh_d;
  logic tfull_q, tfull_d, tcomp_q, tcomp_d, ten_q, ten_d, tpin_q, tpin_d;
  logic tpar_q, tpar_d, tstop2_q, tstop2_d;
  logic [`SXB_CNT_W-1:0] tcnt_q, tcnt_d;
  logic tx_done, tx_load;
  always_comb begin
    tx_st_d = tx_st_q;
    tbuf_d = tbuf_q;
    tsh_d = tsh_q;
    tfull_d = tfull_q;
    tcnt_d = tcnt_q;
    tpin_d = tpin_q;
    tpar_d = tpar_q;
    tstop2_d = tstop2_q;
    tx_done = 1'b0;
    tx_load = 1'b0;
    ten_d = ten_q;
    if (tick) begin
      unique case (tx_st_q)
        SXB_IDLE: tpin_d = 1'b1;
        SXB_START: begin
          tpin_d = 1'b0;
          tx_st_d = SXB_BITS;
          tcnt_d = '0;
        end
        SXB_BITS: begin
          if (tcnt_q < nbits) begin
            tpin_d = tsh_q[0];
            tpar_d = tpar_q ^ tsh_q[0];
            tsh_d = {1'b0, tsh_q[8:1]};
            tcnt_d = tcnt_q + 1'b1;
          end else begin
            tpin_d = tpar_q ^ I_FORMAT.parity_odd;
            tx_st_d = SXB_STOP;
            tcnt_d = '0;
          end
          if (tcnt_q == nbits - 1'b1 && !I_FORMAT.parity_enable) begin
            tx_st_d = SXB_STOP;
            tcnt_d = '0;
          end
        end
        SXB_STOP: begin
          tpin_d = 1'b1;
          tcnt_d = tcnt_q + 1'b1;
          if (tcnt_q == (tstop2_q ? `SXB_CNT_W'(2) : `SXB_CNT_W'(1))) begin
            tx_done = 1'b1;
            tx_st_d = SXB_IDLE;
          end
        end
      endcase
    end
    // Load straight after the last stop bit, or whenever idle.
    if ((tx_st_d == SXB_IDLE) && tfull_q && ten_q) begin
      tx_load = 1'b1;
      tx_st_d = SXB_START;
      // At the end of the last stop bit the next start bit goes out on the same tick, so frames abut.
      if (tx_done) begin
        tpin_d = 1'b0;
        tx_st_d = SXB_BITS;
        tcnt_d = '0;
      end
      tsh_d = tbuf_q & dmask;
      tpar_d = 1'b0;
      tstop2_d = I_FORMAT.two_stop;
      tfull_d = 1'b0;
    end
    if (I_DATA_WRITE && ten_q) begin
      tbuf_d = {I_TX_NINTH_BIT, I_DATA_WDATA};
      tfull_d = 1'b1;
    end
    // Judged on the next values, so a write in the same cycle keeps the transmitter on.
    if (I_TRANSMITTER_ENABLE) begin
      ten_d = 1'b1;
    end else if (!tfull_d && tx_st_d == SXB_IDLE) begin
      ten_d = 1'b0;
    end
    tcomp_d = tcomp_q;
    if (I_TX_COMPLETE_CLEAR || I_TX_COMPLETE_IRQ_ACK) tcomp_d = 1'b0;
    if (tx_done && !tx_load) tcomp_d = 1'b1;
  end
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      tx_st_q <= SXB_IDLE;
      tbuf_q <= '0;
      tsh_q <= '0;
      tfull_q <= 1'b0;
      tcomp_q <= 1'b0;
      ten_q <= 1'b0;
      tpin_q <= 1'b1;
      tcnt_q <= '0;
      tpar_q <= 1'b0;
      tstop2_q <= 1'b0;
    end else if (I_CE) begin
      tx_st_q <= tx_st_d;
      tbuf_q <= tbuf_d;
      tsh_q <= tsh_d;
      tfull_q <= tfull_d;
      tcomp_q <= tcomp_d;
      ten_q <= ten_d;
      tpin_q <= tpin_d;
      tcnt_q <= tcnt_d;
      tpar_q <= tpar_d;
      tstop2_q <= tstop2_d;
    end
  end

  // Receiver. One sample per bit, so a low sample on an idle line is taken as the start bit.
  sxb_state_t rx_st_q, rx_st_d;
  logic [8:0] rsh_q, rsh_d;
  logic [`SXB_CNT_W-1:0] rcnt_q, rcnt_d;
  logic rpar_q, rpar_d, rpbit_q, rpbit_d, rlost_q, rlost_d;
  logic push;
  sxb_pkg::sxb_rx_entry_t rx_entry;
  logic fifo_ready;
  always_comb begin
    rx_st_d = rx_st_q;
    rsh_d = rsh_q;
    rcnt_d = rcnt_q;
    rpar_d = rpar_q;
    rpbit_d = rpbit_q;
    rlost_d = rlost_q;
    push = 1'b0;
    rx_entry = '0;
    if (!I_RECEIVER_ENABLE) begin
      rx_st_d = SXB_IDLE;
      rlost_d = 1'b0;
    end else if (tick) begin
      unique case (rx_st_q)
        SXB_IDLE: begin
          if (!I_RX_PIN) begin
            rx_st_d = SXB_BITS;
            rcnt_d = '0;
            rsh_d = '0;
            rpar_d = 1'b0;
            if (!fifo_ready) rlost_d = 1'b1;
          end
        end
        // Never entered by the receiver; kept so the shared state type stays complete.
        SXB_START: rx_st_d = SXB_IDLE;
        SXB_BITS: begin
          rcnt_d = rcnt_q + 1'b1;
          if (rcnt_q < nbits) begin
            rsh_d = {1'b0, rsh_q[8:1]} | (I_RX_PIN ? (9'h001 << (nbits - 1'b1)) : 9'h000);
            rpar_d = rpar_q ^ I_RX_PIN;
          end else begin
            rpbit_d = I_RX_PIN;
          end
          if (rcnt_q == nbits - (I_FORMAT.parity_enable ? 1'b0 : 1'b1)) rx_st_d = SXB_STOP;
        end
        SXB_STOP: begin
          // The first stop bit ends the frame; a second one is seen as idle line.
          rx_st_d = SXB_IDLE;
          rx_entry.ninth = rsh_q[8];
          rx_entry.data = rsh_q[7:0];
          rx_entry.frame_err = !I_RX_PIN;
          rx_entry.overrun = rlost_q;
          rx_entry.parity_err = I_FORMAT.parity_enable &&
                                (rpar_q ^ rpbit_q ^ I_FORMAT.parity_odd);
          push = fifo_ready;
          if (fifo_ready) rlost_d = 1'b0;
          else rlost_d = 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      rx_st_q <= SXB_IDLE;
      rsh_q <= '0;
      rcnt_q <= '0;
      rpar_q <= 1'b0;
      rpbit_q <= 1'b0;
      rlost_q <= 1'b0;
    end else if (I_CE) begin
      rx_st_q <= rx_st_d;
      rsh_q <= rsh_d;
      rcnt_q <= rcnt_d;
      rpar_q <= rpar_d;
      rpbit_q <= rpbit_d;
      rlost_q <= rlost_d;
    end
  end

  logic head_valid;
  sxb_pkg::sxb_rx_entry_t head;
  // Reading data pops the head, so ninth bit and flags move together.
  sxb_fifo #(.WIDTH($bits(sxb_pkg::sxb_rx_entry_t)), .DEPTH(`SXB_FIFO_DEPTH)) u_fifo (
    .i_clock(I_CLOCK),
    .i_reset(I_RESET),
    .i_ce(I_CE),
    .i_flush(!I_RECEIVER_ENABLE),
    .i_in_valid(push),
    .i_in_data(rx_entry),
    .o_in_ready(fifo_ready),
    .o_out_valid(head_valid),
    .o_out_data(head),
    .i_out_ready(I_DATA_READ)
  );

  // Registered outputs.
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_TX_PIN <= 1'b1;
      O_TX_PIN_OVERRIDE <= 1'b0;
      O_RX_PIN_OVERRIDE <= 1'b0;
      O_TX_BUFFER_EMPTY_FLAG <= 1'b1;
      O_TX_COMPLETE_FLAG <= 1'b0;
      O_RX_COMPLETE_FLAG <= 1'b0;
      O_TX_EMPTY_IRQ <= 1'b0;
      O_TX_COMPLETE_IRQ <= 1'b0;
      O_RX_HEAD <= '0;
    end else if (I_CE) begin
      O_TX_PIN <= tpin_d;
      O_TX_PIN_OVERRIDE <= ten_d;
      O_RX_PIN_OVERRIDE <= I_RECEIVER_ENABLE;
      O_TX_BUFFER_EMPTY_FLAG <= !tfull_d;
      O_TX_COMPLETE_FLAG <= tcomp_d;
      O_RX_COMPLETE_FLAG <= head_valid && !(I_DATA_READ && !I_RECEIVER_ENABLE);
      O_TX_EMPTY_IRQ <= I_TX_EMPTY_IRQ_ENABLE && !tfull_d;
      O_TX_COMPLETE_IRQ <= I_TX_COMPLETE_IRQ_ENABLE && tcomp_d;
      O_RX_HEAD <= head_valid ? head : '0;
    end
  end

  a_empty_tracks: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    (I_CE && I_DATA_WRITE && ten_q) |=> !O_TX_BUFFER_EMPTY_FLAG)
    else $error("Empty flag still set after data write");
  a_empty_irq_level: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    O_TX_EMPTY_IRQ |-> O_TX_BUFFER_EMPTY_FLAG)
    else $error("Empty interrupt without empty flag");
  a_comp_irq_gate: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    O_TX_COMPLETE_IRQ |-> O_TX_COMPLETE_FLAG)
    else $error("Complete interrupt without flag");
  a_comp_clear: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    (I_CE && I_TX_COMPLETE_CLEAR && !tx_done) |=> !O_TX_COMPLETE_FLAG)
    else $error("Complete flag not cleared");
  a_disable_wait: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    (tfull_q && ten_q) |=> ten_q)
    else $error("Transmitter disabled with pending data");
  a_tx_idle_high: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    (!O_TX_PIN_OVERRIDE && $past(!O_TX_PIN_OVERRIDE)) |-> O_TX_PIN)
    else $error("Serial output not idle when released");
  sequence s_rx_off;
    I_CE && !I_RECEIVER_ENABLE;
  endsequence
  a_rx_flush: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    s_rx_off ##1 s_rx_off |=> !O_RX_COMPLETE_FLAG)
    else $error("Receive flag set while disabled");
  a_rx_override: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    I_CE |=> (O_RX_PIN_OVERRIDE == $past(I_RECEIVER_ENABLE)))
    else $error("Receive pin override wrong");
endmodule

// ### testbench/sxb_remote.sv
// Remote serial node: drives the transfer clock, sends frames and collects frames.
// Assumes the block under test runs in synchronous mode on the same system clock.
`timescale 1ns/100ps
module sxb_remote (
  input wire logic i_clock,
  input wire sxb_pkg::sxb_format_t i_format,
  input wire logic i_clk_run,
  input wire logic i_tx_pin,
  output logic o_rx_pin,
  output logic o_xck
);
  logic [2:0] ph = 3'h0;
  logic [11:0] sh = 12'h000;
  logic hold = 1'b0;
  logic q[$];
  logic [11:0] got[$];
  int cnt = 0;
  initial begin
    o_rx_pin = 1'b1;
    o_xck = 1'b0;
  end
  function automatic int nbits();
    return (i_format.char_size == 3'h7) ? 9 : 5 + int'(i_format.char_size);
  endfunction
  // Bad parity or a low stop bit is sent only when the bench asks for it.
  task automatic send(input logic [8:0] v, input logic bp, input logic bs);
    int n;
    n = nbits();
    q.push_back(1'b0);
    for (int i = 0; i < n; i++) q.push_back(v[i]);
    if (i_format.parity_enable) q.push_back(^(v & 9'((1 << n) - 1)) ^ i_format.parity_odd ^ bp);
    q.push_back(~bs);
    if (i_format.two_stop) q.push_back(1'b1);
  endtask
  // The clock stands still between frames unless i_clk_run is high; hold keeps it for the last bit's sample.
  always @(posedge i_clock) begin
    if (i_clk_run || hold || q.size() != 0 || cnt != 0 || ph != 3'h0) begin
      ph <= ph + 3'h1;
      if (ph == 3'h3) o_xck <= 1'b1;
      if (ph == 3'h7) begin
        o_xck <= 1'b0;
        hold = (q.size() != 0);
        o_rx_pin <= (q.size() != 0) ? q.pop_front() : 1'b1;
        if (cnt == 0 && !i_tx_pin) begin
          cnt = 1;
          sh = 12'h000;
        end else if (cnt != 0) begin
          sh[cnt-1] = i_tx_pin;
          if (cnt == nbits() + int'(i_format.parity_enable) + 1) begin
            got.push_back(sh);
            cnt = 0;
          end else cnt = cnt + 1;
        end
      end
    end
  end
endmodule

// ### testbench/serial_txrx_buffer_flags_tb.sv
// Self-checking bench for the serial buffer and flag block.
// Assumes synchronous mode throughout, so the remote node paces every bit.
`timescale 1ns/100ps
module serial_txrx_buffer_flags_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ten = 1'b0, ren = 1'b0, eie = 1'b0, cie = 1'b0, n9 = 1'b0;
  logic wr = 1'b0, rd = 1'b0, tcc = 1'b0, tca = 1'b0, run = 1'b0, ce = 1'b1;
  logic [7:0] wd = 8'h00;
  sxb_pkg::sxb_format_t fmt = '0;
  logic txp, txo, rxo, tef, tcf, rcf, tei, tci, rxp, transfer_clock_pin;
  sxb_pkg::sxb_rx_entry_t head;
  logic [31:0] lfsr = 32'hB2EACBDC;
  logic [2:0] sizes[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  logic [8:0] txq[$];
  logic [11:0] exq[$];
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  sxb_top #(.BAUD_DIV(16'h0003)) i_sxb_top (
    .I_CLOCK(clk), .I_RESET(rst), .I_CE(ce), .I_FORMAT(fmt),
    .I_TRANSMITTER_ENABLE(ten), .I_RECEIVER_ENABLE(ren), .I_TX_EMPTY_IRQ_ENABLE(eie),
    .I_TX_COMPLETE_IRQ_ENABLE(cie), .I_TX_NINTH_BIT(n9), .I_DATA_WRITE(wr),
    .I_DATA_WDATA(wd), .I_DATA_READ(rd), .I_TX_COMPLETE_CLEAR(tcc),
    .I_TX_COMPLETE_IRQ_ACK(tca), .I_RX_PIN(rxp), .I_TRANSFER_CLOCK_PIN(transfer_clock_pin),
    .O_TX_PIN(txp), .O_TX_PIN_OVERRIDE(txo), .O_RX_PIN_OVERRIDE(rxo),
    .O_TX_BUFFER_EMPTY_FLAG(tef), .O_TX_COMPLETE_FLAG(tcf), .O_RX_COMPLETE_FLAG(rcf),
    .O_TX_EMPTY_IRQ(tei), .O_TX_COMPLETE_IRQ(tci), .O_RX_HEAD(head));
  sxb_remote i_sxb_remote (.i_clock(clk), .i_format(fmt), .i_clk_run(run),
    .i_tx_pin(txp), .o_rx_pin(rxp), .o_xck(transfer_clock_pin));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int nb(input logic [2:0] cs);
    return (cs == 3'h7) ? 9 : 5 + int'(cs);
  endfunction
  function automatic logic [8:0] msk(input int n, input logic [8:0] v);
    return v & 9'((1 << n) - 1);
  endfunction
  // Expected line bits after the start bit: data LSB first, parity, first stop.
  function automatic logic [11:0] tx_frame(input logic [8:0] v);
    int n;
    logic [8:0] d;
    n = nb(fmt.char_size);
    d = msk(n, v);
    return 12'(d) | (12'(fmt.parity_enable ? {1'b1, ^d ^ fmt.parity_odd} : 2'b01) << n);
  endfunction
  task automatic chk_flag(input logic g, input logic e, input string m);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic chk_word(input logic [11:0] g, input logic [11:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic tx_word;
    logic [8:0] v;
    v = lfsr[8:0];
    lfsr = lfsr_next(lfsr);
    txq.push_back(v);
    @(posedge clk);
    n9 <= v[8];
    wd <= v[7:0];
    // Only the data strobe is written; the empty flag has no write path here.
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rx_frame(input logic bs, input logic ov);
    logic [8:0] v;
    logic bp;
    v = lfsr[8:0];
    bp = lfsr[9] & fmt.parity_enable;
    lfsr = lfsr_next(lfsr);
    i_sxb_remote.send(v, bp, bs);
    exq.push_back({msk(nb(fmt.char_size), v), bs, ov, bp});
  endtask
  task automatic settle;
    for (int i = 0; i < 2000 && i_sxb_remote.q.size() != 0; i++) @(posedge clk);
    cyc_n(24);
  endtask
  // Head is compared before each pop, as software reads status and ninth bit first.
  task automatic drain(input int k);
    for (int i = 0; i < k; i++) begin
      chk_flag(rcf, 1'b1, "rx ready");
      chk_word(head, exq.pop_front(), "rx entry");
      @(posedge clk);
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      cyc_n(2);
    end
    chk_flag(rcf, exq.size() != 0, "rx level");
  endtask
  task automatic tx_pair(input logic ack);
    @(posedge clk);
    run <= 1'b1;
    tx_word;
    cyc_n(1);
    for (int i = 0; i < 8 && tef !== 1'b1; i++) cyc_n(1);
    tx_word;
    cyc_n(2);
    chk_flag(tef, 1'b0, "buffer held");
    chk_flag(tei, 1'b0, "empty irq off");
    chk_flag(tcf, 1'b0, "complete early");
    for (int i = 0; i < 600 && i_sxb_remote.got.size() < 2; i++) @(posedge clk);
    for (int i = 0; i < 2; i++) begin
      chk_word(i_sxb_remote.got.pop_front(), tx_frame(txq.pop_front()), "tx frame");
    end
    for (int i = 0; i < 60 && tcf !== 1'b1; i++) @(posedge clk);
    cyc_n(2);
    chk_flag(tcf, 1'b1, "complete");
    chk_flag(tef, 1'b1, "buffer empty");
    chk_flag(tci, ack, "complete irq");
    @(posedge clk);
    tca <= ack;
    tcc <= ~ack;
    run <= 1'b0;
    @(posedge clk);
    tca <= 1'b0;
    tcc <= 1'b0;
    cyc_n(2);
    chk_flag(tcf, 1'b0, "complete cleared");
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      $display("FAIL %0t timeout", $time);
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc_n(1);
    chk_flag(tef, 1'b1, "empty at reset");
    chk_flag(txp, 1'b1, "line idle");
    chk_flag(tcf | rcf | tci | txo | rxo, 1'b0, "flags at reset");
    @(posedge clk);
    ce <= 1'b0;
    fmt.sync_mode <= 1'b1;
    ten <= 1'b1;
    ren <= 1'b1;
    eie <= 1'b1;
    cyc_n(3);
    chk_flag(tei | txo | rxo, 1'b0, "frozen by clock enable");
    @(posedge clk);
    ce <= 1'b1;
    cyc_n(3);
    chk_flag(txo, 1'b1, "tx override");
    chk_flag(rxo, 1'b1, "rx override");
    chk_flag(tei, 1'b1, "empty irq");
    for (int k = 0; k < 10; k++) begin
      @(posedge clk);
      fmt.char_size <= sizes[k / 2];
      fmt.parity_enable <= k[0];
      fmt.parity_odd <= lfsr[3];
      fmt.two_stop <= lfsr[4];
      cie <= k[0];
      cyc_n(1);
      tx_pair(k[0]);
      rx_frame(1'b0, 1'b0);
      rx_frame(lfsr[5], 1'b0);
      settle;
      drain(2);
    end
    @(posedge clk);
    fmt.char_size <= 3'h3;
    fmt.parity_enable <= 1'b0;
    fmt.two_stop <= 1'b0;
    cyc_n(1);
    for (int i = 0; i < 17; i++) rx_frame(1'b0, 1'b0);
    void'(exq.pop_back());
    settle;
    drain(1);
    rx_frame(1'b0, 1'b1);
    settle;
    drain(16);
    rx_frame(1'b0, 1'b0);
    settle;
    @(posedge clk);
    ren <= 1'b0;
    cyc_n(2);
    chk_flag(rcf, 1'b0, "flushed");
    chk_flag(rxo, 1'b0, "rx released");
    void'(exq.pop_back());
    @(posedge clk);
    ren <= 1'b1;
    run <= 1'b1;
    tx_word;
    ten <= 1'b0;
    eie <= 1'b0;
    cyc_n(6);
    chk_flag(txo, 1'b1, "disable held");
    chk_flag(tei, 1'b0, "irq masked");
    for (int i = 0; i < 400 && i_sxb_remote.got.size() < 1; i++) @(posedge clk);
    chk_word(i_sxb_remote.got.pop_front(), tx_frame(txq.pop_front()), "last frame");
    cyc_n(30);
    chk_flag(txo, 1'b0, "tx released");
    tx_word;
    cyc_n(2);
    chk_flag(tef, 1'b1, "write dropped");
    end_of_test;
  end
endmodule
